// file: hdl/aam_pkg.sv
// Constants, encodings and register map of the pointer/MAC datapath
package aam_pkg;
  localparam int AHB_AW = 32;
  localparam int RPT_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_IMM = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_PROD = 8'h0c;
  localparam logic [7:0] OFS_MULT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PREFETCH = 8'h18;
  localparam logic [7:0] OFS_RPT = 8'h1c;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
  localparam logic [7:0] OFS_DMEM_DATA = 8'h24;
  localparam logic [7:0] OFS_PMEM_DATA = 8'h28;
  localparam logic [2:0] OFS_PTR_PAGE = 3'h2;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 5;
  localparam int CMD_SELEN_BIT = 8;
  localparam int CMD_SEL_LSB = 9;
  localparam int CMD_K_LSB = 16;
  // Status word fields
  localparam int ST_SEL_LSB = 0;
  localparam int ST_CARRY_BIT = 3;
  localparam int ST_OVF_BIT = 4;
  localparam int ST_PSH_LSB = 5;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_TAKEN_BIT = 8;
  // Values after reset
  localparam logic READY_RST = 1'b1;
  localparam logic RESP_OKAY = 1'b0;
  // Timing: one instruction must fit in one instruction cycle
  localparam int INSTR_CYCLE_NS = 100;
  localparam int CLK_PERIOD_NS = 20;
  localparam int EXEC_MAX_CYCLES = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int EXEC_CYCLES = 1;

  typedef enum logic [4:0] {
    OP_NOP = 5'b00000,
    OP_MAC_WITH_DATA_MOVE = 5'b00001,
    OP_MULTIPLY_BY_CONSTANT = 5'b00010,
    OP_LOAD_MULT_AND_ADD = 5'b00011,
    OP_LOAD_MULT_AND_SUBTRACT = 5'b00100,
    OP_LOAD_MULT_AND_MOVE_PRODUCT = 5'b00101,
    OP_LOAD_MULT_ADD_DATA_MOVE = 5'b00110,
    OP_MULTIPLY_AND_ACCUMULATE_PREV = 5'b00111,
    OP_MULTIPLY_AND_SUBTRACT_PREV = 5'b01000,
    OP_DATA_BLOCK_MOVE = 5'b01001,
    OP_PROG_TO_DATA_BLOCK_MOVE = 5'b01010,
    OP_NORMALIZE_ACCUMULATOR = 5'b01011,
    OP_LOAD_ACC_VARIABLE_SHIFT = 5'b01100,
    OP_ADD_VARIABLE_SHIFT = 5'b01101,
    OP_SUBTRACT_VARIABLE_SHIFT = 5'b01110,
    OP_ADD_SHORT_IMM = 5'b01111,
    OP_LOAD_PTR_LONG_IMM = 5'b10000,
    OP_BRANCH_PTR_NONZERO = 5'b10001
  } aam_op_t;

  typedef enum logic [2:0] {
    IDX_NONE = 3'b000,
    IDX_INC = 3'b001,
    IDX_DEC = 3'b010,
    IDX_ADD = 3'b011,
    IDX_SUB = 3'b100,
    IDX_RC_ADD = 3'b101,
    IDX_RC_SUB = 3'b110
  } aam_idx_t;

  typedef enum logic [1:0] {
    PSH_NONE = 2'b00,
    PSH_LEFT1 = 2'b01,
    PSH_LEFT4 = 2'b10,
    PSH_RIGHT6 = 2'b11
  } aam_pshift_t;
endpackage

// file: hdl/aam_datapath.sv
// Pointer arithmetic and multiply/accumulate datapath behind an AHB-Lite slave
//
// Functional notes
// - Pointer update choices: +1, -1, +index, -index, reverse-carry +/-index, none.
// - Update hits the selected pointer in the same cycle; select may be reloaded.
// - Pointer update also happens during the pointer-nonzero branch.
// - Reverse-carry mode propagates carries from msb toward lsb for bit reversal.
// - Short immediates are 8 or 13 bits in command; long is 16 bits.
// - Multiply-by-constant uses multiplicand times signed 13-bit constant.
// - The whole multiply/accumulate/data-move finishes in one clock.
// - Product passes output shifter and is added into the 32-bit accumulator.
// - Addressed data word is loaded into the multiplicand register.
// - Program word times multiplicand, new product kept for next accumulation.
// - Addressed data word is copied to the next higher address.
// - Accumulation updates carry and overflow flags.
// - Selected pointer is modified, normally decremented, for the next operand.
// - Prefetch counter increments to address the next program operand.
// - Each execution with a nonzero repeat counter decrements it; one at zero clears busy instead.
// - Combined ops load multiplicand with add, subtract, product move, or data move.
// - Multiply-accumulate/subtract uses previous product while forming a new one.
// - Block moves read at prefetch counter, write at indexed pointer.
// - Normalize shifts the accumulator left.
// - Variable-shift ops shift operand left by multiplicand low four bits.
// - Three-bit pointer select chooses one of eight pointers.
`timescale 1ns/10ps
module aam_datapath #(
  parameter int DM_AW = 4,
  parameter int PM_AW = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [aam_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import aam_pkg::*;

  localparam int DM_DEPTH = 2 ** DM_AW;
  localparam int PM_DEPTH = 2 ** PM_AW;

  typedef struct packed {
    logic [DM_DEPTH-1:0][15:0] dmem;
    logic [PM_DEPTH-1:0][15:0] pmem;
    logic [7:0][15:0] ptr;
    logic [31:0] acc;
    logic [31:0] prod;
    logic [15:0] mult;
    logic [15:0] imm;
    logic [15:0] prefetch;
    logic [15:0] maddr;
    logic [RPT_W-1:0] rpt;
    logic [31:0] cmd;
    logic [2:0] psel;
    logic carry;
    logic ovf;
    logic taken;
    logic busy;
    aam_pshift_t pshift;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } aam_state_t;

  aam_state_t r_reg;
  aam_state_t r_next;

  function automatic logic [15:0] bit_rev(input logic [15:0] v);
    logic [15:0] o;
    o = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      o[i] = v[15-i];
    end
    return o;
  endfunction

  // Mirror, add, mirror: carries run toward the lsb and fall off there
  function automatic logic [15:0] rc_step(input logic [15:0] a, input logic [15:0] b, input logic sub);
    logic [15:0] s;
    s = sub ? (bit_rev(a) - bit_rev(b)) : (bit_rev(a) + bit_rev(b));
    return bit_rev(s);
  endfunction

  function automatic logic [15:0] ptr_update(input logic [15:0] cur, input logic [15:0] idx,
                                             input logic [2:0] mode);
    logic [15:0] o;
    o = cur;
    case (mode)
      IDX_INC: o = cur + 16'h0001;
      IDX_DEC: o = cur - 16'h0001;
      IDX_ADD: o = cur + idx;
      IDX_SUB: o = cur - idx;
      IDX_RC_ADD: o = rc_step(cur, idx, 1'b0);
      IDX_RC_SUB: o = rc_step(cur, idx, 1'b1);
      default: o = cur;
    endcase
    return o;
  endfunction

  function automatic logic [31:0] out_shift(input logic [31:0] p, input aam_pshift_t m);
    logic [31:0] o;
    case (m)
      PSH_LEFT1: o = {p[30:0], 1'b0};
      PSH_LEFT4: o = {p[27:0], 4'h0};
      PSH_RIGHT6: o = {{6{p[31]}}, p[31:6]};
      default: o = p;
    endcase
    return o;
  endfunction

  function automatic logic [31:0] in_shift(input logic [15:0] d, input logic [3:0] amt);
    logic [31:0] ext;
    ext = {{16{d[15]}}, d};
    return ext << amt;
  endfunction

  function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return p;
  endfunction

  // Result in [31:0], carry in [32], overflow in [33]
  function automatic logic [33:0] acc_op(input logic [31:0] a, input logic [31:0] b, input logic sub);
    logic [32:0] s;
    logic c;
    logic v;
    if (sub) begin
      s = {1'b0, a} - {1'b0, b};
      c = ~s[32];
      v = (a[31] != b[31]) && (s[31] != a[31]);
    end else begin
      s = {1'b0, a} + {1'b0, b};
      c = s[32];
      v = (a[31] == b[31]) && (s[31] != a[31]);
    end
    return {v, c, s[31:0]};
  endfunction

  logic [4:0] op;
  logic [2:0] idx_mode;
  logic [12:0] k13;
  logic [15:0] cur_ptr;
  logic [15:0] operand;
  logic [15:0] pword;
  logic [15:0] next_ptr;
  logic [31:0] scaled_prod;
  logic [33:0] acc_res;
  logic acc_flags;
  logic [31:0] rdv;
  logic accept;
  logic [DM_AW-1:0] move_addr;

  always_comb begin
    r_next = r_reg;
    op = r_reg.cmd[CMD_OP_LSB +: 5];
    idx_mode = r_reg.cmd[CMD_IDX_LSB +: 3];
    k13 = r_reg.cmd[CMD_K_LSB +: 13];
    cur_ptr = r_reg.ptr[r_reg.psel];
    operand = r_reg.dmem[cur_ptr[DM_AW-1:0]];
    pword = r_reg.pmem[r_reg.prefetch[PM_AW-1:0]];
    // Pointer zero doubles as the index register
    next_ptr = ptr_update(cur_ptr, r_reg.ptr[0], idx_mode);
    // Data move target wraps inside the small data memory
    move_addr = cur_ptr[DM_AW-1:0] + DM_AW'(1);
    scaled_prod = out_shift(r_reg.prod, r_reg.pshift);
    acc_res = '0;
    acc_flags = 1'b0;
    rdv = 32'h00000000;
    accept = hsel && htrans[1] && hready;

    // One execution per clock, well inside one instruction cycle
    if (r_reg.busy) begin
      case (op)
        OP_MAC_WITH_DATA_MOVE: begin
          acc_res = acc_op(r_reg.acc, scaled_prod, 1'b0);
          acc_flags = 1'b1;
          r_next.mult = operand;
          r_next.prod = mul16(operand, pword);
          r_next.dmem[move_addr] = operand;
          r_next.prefetch = r_reg.prefetch + 16'h0001;
        end
        OP_MULTIPLY_BY_CONSTANT: begin
          r_next.prod = mul16(r_reg.mult, {{3{k13[12]}}, k13});
        end
        OP_LOAD_MULT_AND_ADD, OP_LOAD_MULT_ADD_DATA_MOVE: begin
          acc_res = acc_op(r_reg.acc, scaled_prod, 1'b0);
          acc_flags = 1'b1;
          r_next.mult = operand;
          if (op == OP_LOAD_MULT_ADD_DATA_MOVE) begin
            r_next.dmem[move_addr] = operand;
          end
        end
        OP_LOAD_MULT_AND_SUBTRACT: begin
          acc_res = acc_op(r_reg.acc, scaled_prod, 1'b1);
          acc_flags = 1'b1;
          r_next.mult = operand;
        end
        OP_LOAD_MULT_AND_MOVE_PRODUCT: begin
          r_next.acc = scaled_prod;
          r_next.mult = operand;
        end
        OP_MULTIPLY_AND_ACCUMULATE_PREV, OP_MULTIPLY_AND_SUBTRACT_PREV: begin
          acc_res = acc_op(r_reg.acc, scaled_prod, op == OP_MULTIPLY_AND_SUBTRACT_PREV);
          acc_flags = 1'b1;
          r_next.prod = mul16(r_reg.mult, operand);
        end
        OP_DATA_BLOCK_MOVE: begin
          r_next.dmem[cur_ptr[DM_AW-1:0]] = r_reg.dmem[r_reg.prefetch[DM_AW-1:0]];
          r_next.prefetch = r_reg.prefetch + 16'h0001;
        end
        OP_PROG_TO_DATA_BLOCK_MOVE: begin
          r_next.dmem[cur_ptr[DM_AW-1:0]] = pword;
          r_next.prefetch = r_reg.prefetch + 16'h0001;
        end
        OP_NORMALIZE_ACCUMULATOR: begin
          // One step per execution; repeat to finish a full normalize
          if (r_reg.acc != 32'h00000000 && r_reg.acc[31] == r_reg.acc[30]) begin
            r_next.acc = {r_reg.acc[30:0], 1'b0};
          end
        end
        OP_LOAD_ACC_VARIABLE_SHIFT: begin
          r_next.acc = in_shift(operand, r_reg.mult[3:0]);
        end
        OP_ADD_VARIABLE_SHIFT, OP_SUBTRACT_VARIABLE_SHIFT: begin
          acc_res = acc_op(r_reg.acc, in_shift(operand, r_reg.mult[3:0]),
                           op == OP_SUBTRACT_VARIABLE_SHIFT);
          acc_flags = 1'b1;
        end
        OP_ADD_SHORT_IMM: begin
          acc_res = acc_op(r_reg.acc, {24'h000000, k13[7:0]}, 1'b0);
          acc_flags = 1'b1;
        end
        OP_BRANCH_PTR_NONZERO: begin
          r_next.taken = (cur_ptr != 16'h0000);
        end
        default: begin
        end
      endcase
      // Overflow stays set until software clears it; carry follows each result
      if (acc_flags) begin
        r_next.acc = acc_res[31:0];
        r_next.carry = acc_res[32];
        r_next.ovf = r_reg.ovf | acc_res[33];
      end
      // Long immediate stands in for the word after the opcode
      if (op == OP_LOAD_PTR_LONG_IMM) begin
        r_next.ptr[r_reg.psel] = r_reg.imm;
      end else begin
        r_next.ptr[r_reg.psel] = next_ptr;
      end
      if (r_reg.cmd[CMD_SELEN_BIT]) begin
        r_next.psel = r_reg.cmd[CMD_SEL_LSB +: 3];
      end
      if (r_reg.rpt != '0) begin
        r_next.rpt = r_reg.rpt - 1'b1;
      end else begin
        r_next.busy = 1'b0;
      end
    end

    // Write data phase; refused while executing so no field has two writers
    if (r_reg.wr_pend && !r_reg.busy) begin
      if (r_reg.addr[7:2] == OFS_CMD[7:2]) begin
        r_next.cmd = hwdata;
        r_next.busy = 1'b1;
        r_next.taken = 1'b0;
      end else if (r_reg.addr[7:2] == OFS_IMM[7:2]) begin
        r_next.imm = hwdata[15:0];
      end else if (r_reg.addr[7:2] == OFS_ACC[7:2]) begin
        r_next.acc = hwdata;
      end else if (r_reg.addr[7:2] == OFS_PROD[7:2]) begin
        r_next.prod = hwdata;
      end else if (r_reg.addr[7:2] == OFS_MULT[7:2]) begin
        r_next.mult = hwdata[15:0];
      end else if (r_reg.addr[7:2] == OFS_STATUS[7:2]) begin
        r_next.psel = hwdata[ST_SEL_LSB +: 3];
        r_next.carry = hwdata[ST_CARRY_BIT];
        r_next.ovf = hwdata[ST_OVF_BIT];
        r_next.pshift = aam_pshift_t'(hwdata[ST_PSH_LSB +: 2]);
      end else if (r_reg.addr[7:2] == OFS_PREFETCH[7:2]) begin
        r_next.prefetch = hwdata[15:0];
      end else if (r_reg.addr[7:2] == OFS_RPT[7:2]) begin
        r_next.rpt = hwdata[RPT_W-1:0];
      end else if (r_reg.addr[7:2] == OFS_MEM_ADDR[7:2]) begin
        r_next.maddr = hwdata[15:0];
      end else if (r_reg.addr[7:2] == OFS_DMEM_DATA[7:2]) begin
        r_next.dmem[r_reg.maddr[DM_AW-1:0]] = hwdata[15:0];
      end else if (r_reg.addr[7:2] == OFS_PMEM_DATA[7:2]) begin
        r_next.pmem[r_reg.maddr[PM_AW-1:0]] = hwdata[15:0];
      end else if (r_reg.addr[7:5] == OFS_PTR_PAGE) begin
        r_next.ptr[r_reg.addr[4:2]] = hwdata[15:0];
      end
    end

    // Read data phase: one wait state so a write just before is seen
    if (r_reg.addr[7:2] == OFS_CMD[7:2]) begin
      rdv = r_reg.cmd;
    end else if (r_reg.addr[7:2] == OFS_IMM[7:2]) begin
      rdv = {16'h0000, r_reg.imm};
    end else if (r_reg.addr[7:2] == OFS_ACC[7:2]) begin
      rdv = r_reg.acc;
    end else if (r_reg.addr[7:2] == OFS_PROD[7:2]) begin
      rdv = r_reg.prod;
    end else if (r_reg.addr[7:2] == OFS_MULT[7:2]) begin
      rdv = {16'h0000, r_reg.mult};
    end else if (r_reg.addr[7:2] == OFS_STATUS[7:2]) begin
      rdv[ST_SEL_LSB +: 3] = r_reg.psel;
      rdv[ST_CARRY_BIT] = r_reg.carry;
      rdv[ST_OVF_BIT] = r_reg.ovf;
      rdv[ST_PSH_LSB +: 2] = r_reg.pshift;
      rdv[ST_BUSY_BIT] = r_reg.busy;
      rdv[ST_TAKEN_BIT] = r_reg.taken;
    end else if (r_reg.addr[7:2] == OFS_PREFETCH[7:2]) begin
      rdv = {16'h0000, r_reg.prefetch};
    end else if (r_reg.addr[7:2] == OFS_RPT[7:2]) begin
      rdv = {{(32-RPT_W){1'b0}}, r_reg.rpt};
    end else if (r_reg.addr[7:2] == OFS_MEM_ADDR[7:2]) begin
      rdv = {16'h0000, r_reg.maddr};
    end else if (r_reg.addr[7:2] == OFS_DMEM_DATA[7:2]) begin
      rdv = {16'h0000, r_reg.dmem[r_reg.maddr[DM_AW-1:0]]};
    end else if (r_reg.addr[7:2] == OFS_PMEM_DATA[7:2]) begin
      rdv = {16'h0000, r_reg.pmem[r_reg.maddr[PM_AW-1:0]]};
    end else if (r_reg.addr[7:5] == OFS_PTR_PAGE) begin
      rdv = {16'h0000, r_reg.ptr[r_reg.addr[4:2]]};
    end
    if (r_reg.rd_pend) begin
      r_next.rdata = rdv;
      r_next.ready = 1'b1;
    end

    // Address phase; only full-word single transfers are expected
    r_next.wr_pend = 1'b0;
    r_next.rd_pend = 1'b0;
    if (accept) begin
      r_next.addr = haddr[7:0];
      if (hwrite) begin
        r_next.wr_pend = 1'b1;
      end else begin
        r_next.rd_pend = 1'b1;
        r_next.ready = 1'b0;
      end
    end
    // No transfer can fail here, so the response is fixed
    r_next.resp = RESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.ready <= READY_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.rdata;
  assign hreadyout = r_reg.ready;
  assign hresp = r_reg.resp;
endmodule

// file: verif/aam_datapath_monitor.sv
// Port checker for the datapath register bus
`timescale 1ns/10ps
module aam_datapath_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [aam_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  import aam_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && hwrite;
  resp_okay_a: assert property (hresp == RESP_OKAY) else $error("hresp not okay");
  read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  write_nowait_a: assert property (wr_take |=> hreadyout) else $error("write stalled");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take)) else $error("stray wait");
  rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
  ptr_width_a: assert property (rd_take && haddr[7:5] == OFS_PTR_PAGE |-> ##2 hrdata[31:16] == 16'h0)
    else $error("pointer upper bits set");
  status_width_a: assert property (rd_take && haddr[7:0] == OFS_STATUS |-> ##2 hrdata[31:9] == 23'h0)
    else $error("status upper bits set");
  pfc_width_a: assert property (rd_take && haddr[7:0] == OFS_PREFETCH |-> ##2 hrdata[31:16] == 16'h0)
    else $error("prefetch upper bits set");
  rpt_width_a: assert property (rd_take && haddr[7:0] == OFS_RPT |-> ##2 hrdata[31:RPT_W] == '0)
    else $error("repeat upper bits set");
  cover property (rd_take);
  cover property (wr_take);
  cover property (rd_take && haddr[7:0] == OFS_STATUS);
endmodule

// file: verif/aam_ahb_master.sv
// AHB-Lite master model for the datapath register bus
`timescale 1ns/10ps
module aam_ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [aam_pkg::AHB_AW-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Bounded, so a stuck slave ends the run
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) aam_datapath_bench.finish_test(1);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask
endmodule

// file: verif/aam_datapath_bench.sv
// Random and corner bench for the pointer/MAC datapath
`timescale 1ns/10ps
module aam_datapath_bench;
  import aam_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic [AHB_AW-1:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h1b2e1f3e;
  logic [31:0] rv, acc, prd, sh;
  logic [32:0] sum;
  logic [15:0] ix, p, d, q;
  logic [12:0] k;
  logic [2:0] ns;
  always #10 hclk = ~hclk;
  aam_datapath #(.DM_AW(4), .PM_AW(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  aam_ahb_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task finish_test(input int extra);
    error_cnt += extra;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    m.xfer(a, 1'b1, v, rv);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    m.xfer(a, 1'b0, $random(seed), rv);
    chk(rv, e);
  endtask
  task mem(input logic [7:0] a, input logic [15:0] v, input logic [7:0] port);
    wr(OFS_MEM_ADDR, {24'h0, a});
    wr(port, {16'h0, v});
  endtask
  // Busy polling is bounded; a stuck busy ends the run
  task run(input aam_op_t op, input aam_idx_t md, input logic [2:0] sel, input logic [12:0] kk);
    int n;
    n = 0;
    wr(OFS_CMD, {3'h0, kk, 4'h0, sel, 1'b1, md, op});
    do begin
      m.xfer(OFS_STATUS, 1'b0, 32'h0, rv);
      n++;
    end while (rv[ST_BUSY_BIT] !== 1'b0 && n < 50);
    if (rv[ST_BUSY_BIT] !== 1'b0) finish_test(1);
  endtask
  function automatic logic [15:0] rev(input logic [15:0] x);
    for (int i = 0; i < 16; i++) rev[i] = x[15-i];
  endfunction
  function automatic logic [15:0] upd(input logic [15:0] a, input logic [15:0] x, input int md);
    case (md)
      1: upd = a + 16'h1;
      2: upd = a - 16'h1;
      3: upd = a + x;
      4: upd = a - x;
      5: upd = rev(rev(a) + rev(x));
      6: upd = rev(rev(a) - rev(x));
      default: upd = a;
    endcase
  endfunction
  function automatic logic [31:0] psh(input logic [31:0] v, input int m);
    case (m)
      1: psh = v << 1;
      2: psh = v << 4;
      3: psh = $signed(v) >>> 6;
      default: psh = v;
    endcase
  endfunction
  function automatic logic [31:0] sx(input logic [15:0] v);
    sx = {{16{v[15]}}, v};
  endfunction
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 2; i < 8; i++) rdchk(8'(i * 4), 32'h0);
    $display("reset test done");
    for (int i = 0; i < 14; i++) begin
      p = (i == 1) ? 16'hffff : $random(seed);
      ix = (i == 5) ? 16'h8000 : $random(seed);
      ns = $random(seed);
      wr(8'h40, {16'h0, ix});
      wr(8'h4c, {16'h0, p});
      wr(OFS_STATUS, 32'h3);
      run(OP_NOP, aam_idx_t'(i % 7), ns, 13'h0);
      rdchk(8'h4c, {16'h0, upd(p, ix, i % 7)});
      rdchk(OFS_STATUS, {29'h0, ns});
    end
    $display("pointer test done");
    wr(8'h44, 32'h1);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_STATUS, 32'h1);
      run(OP_BRANCH_PTR_NONZERO, IDX_DEC, 3'h1, 13'h0);
      rdchk(8'h44, j ? 32'hffff : 32'h0);
      rdchk(OFS_STATUS, {23'h0, j == 0, 8'h1});
    end
    $display("branch test done");
    for (int j = 0; j < 2; j++) begin
      d = $random(seed);
      q = $random(seed);
      acc = j ? 32'h7fffffff : $random(seed);
      prd = j ? 32'h1 : $random(seed);
      mem(8'h5, d, OFS_DMEM_DATA);
      mem(8'h9, q, OFS_PMEM_DATA);
      wr(8'h48, 32'h5);
      wr(OFS_PREFETCH, 32'h9);
      wr(OFS_ACC, acc);
      wr(OFS_PROD, prd);
      wr(OFS_STATUS, 32'h2);
      run(OP_MAC_WITH_DATA_MOVE, IDX_DEC, 3'h2, 13'h0);
      sum = {1'b0, acc} + {1'b0, prd};
      rdchk(OFS_ACC, sum[31:0]);
      rdchk(OFS_MULT, {16'h0, d});
      rdchk(OFS_PROD, sx(d) * sx(q));
      rdchk(OFS_STATUS, {27'h0, acc[31] == prd[31] && sum[31] != acc[31], sum[32], 3'h2});
      rdchk(8'h48, 32'h4);
      rdchk(OFS_PREFETCH, 32'ha);
      wr(OFS_MEM_ADDR, 32'h6);
      rdchk(OFS_DMEM_DATA, {16'h0, d});
    end
    $display("mac test done");
    for (int j = 0; j < 2; j++) begin
      d = $random(seed);
      k = j ? 13'h1000 : $random(seed);
      wr(OFS_MULT, {16'h0, d});
      run(OP_MULTIPLY_BY_CONSTANT, IDX_NONE, 3'h2, k);
      rdchk(OFS_PROD, sx(d) * {{19{k[12]}}, k});
    end
    for (int j = 12; j < 15; j++) begin
      q = $random(seed);
      d = {1'b0, q[14:0]};
      acc = $random(seed);
      mem(8'h3, d, OFS_DMEM_DATA);
      wr(8'h48, 32'h3);
      wr(OFS_ACC, acc);
      wr(OFS_MULT, {16'h0, q});
      run(aam_op_t'(j), IDX_NONE, 3'h2, 13'h0);
      sh = {16'h0, d} << q[3:0];
      rdchk(OFS_ACC, j == 12 ? sh : (j == 13 ? acc + sh : acc - sh));
    end
    $display("shift test done");
    for (int j = 4; j < 9; j++) begin
      d = $random(seed);
      q = $random(seed);
      acc = $random(seed);
      prd = $random(seed);
      mem(8'h6, d, OFS_DMEM_DATA);
      wr(8'h48, 32'h6);
      wr(OFS_ACC, acc);
      wr(OFS_PROD, prd);
      wr(OFS_MULT, {16'h0, q});
      wr(OFS_STATUS, {25'h0, 2'(j % 4), 5'h2});
      run(aam_op_t'(j), IDX_DEC, 3'h2, 13'h0);
      sh = psh(prd, j % 4);
      rdchk(OFS_ACC, j == 5 ? sh : ((j == 4 || j == 8) ? acc - sh : acc + sh));
      rdchk(OFS_MULT, {16'h0, j > 6 ? q : d});
      rdchk(OFS_PROD, j > 6 ? sx(q) * sx(d) : prd);
      rdchk(8'h48, 32'h5);
      if (j == 6) begin
        wr(OFS_MEM_ADDR, 32'h7);
        rdchk(OFS_DMEM_DATA, {16'h0, d});
      end
    end
    $display("combined op test done");
    for (int j = 0; j < 2; j++) begin
      wr(OFS_ACC, j ? 32'h40000000 : 32'h00001234);
      run(OP_NORMALIZE_ACCUMULATOR, IDX_NONE, 3'h2, 13'h0);
      rdchk(OFS_ACC, j ? 32'h40000000 : 32'h00002468);
    end
    k = $random(seed);
    acc = $random(seed);
    ix = $random(seed);
    wr(OFS_ACC, acc);
    run(OP_ADD_SHORT_IMM, IDX_NONE, 3'h2, k);
    rdchk(OFS_ACC, acc + {24'h0, k[7:0]});
    wr(OFS_IMM, {16'h0, ix});
    run(OP_LOAD_PTR_LONG_IMM, IDX_INC, 3'h2, 13'h0);
    rdchk(8'h48, {16'h0, ix});
    $display("immediate test done");
    d = $random(seed);
    q = $random(seed);
    mem(8'h7, d, OFS_PMEM_DATA);
    mem(8'h8, q, OFS_PMEM_DATA);
    wr(OFS_PREFETCH, 32'h7);
    wr(8'h48, 32'h2);
    wr(OFS_RPT, 32'h1);
    run(OP_PROG_TO_DATA_BLOCK_MOVE, IDX_INC, 3'h2, 13'h0);
    rdchk(OFS_RPT, 32'h0);
    rdchk(8'h48, 32'h4);
    rdchk(OFS_PREFETCH, 32'h9);
    wr(OFS_MEM_ADDR, 32'h2);
    rdchk(OFS_DMEM_DATA, {16'h0, d});
    wr(OFS_MEM_ADDR, 32'h3);
    rdchk(OFS_DMEM_DATA, {16'h0, q});
    rdchk(8'h60, 32'h0);
    wr(OFS_PREFETCH, 32'h2);
    wr(8'h48, 32'hc);
    wr(OFS_RPT, 32'h1);
    run(OP_DATA_BLOCK_MOVE, IDX_DEC, 3'h2, 13'h0);
    rdchk(8'h48, 32'ha);
    rdchk(OFS_PREFETCH, 32'h4);
    wr(OFS_MEM_ADDR, 32'hb);
    rdchk(OFS_DMEM_DATA, {16'h0, q});
    $display("block test done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(OFS_STATUS, 32'h0);
    rdchk(OFS_ACC, 32'h0);
    $display("second reset test done");
    finish_test(0);
  end
endmodule
bind aam_datapath aam_datapath_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
